// File: capture_defs.svh
// offsets, field positions, reset values and counts of the capture unit
`ifndef CAPTURE_DEFS_SVH
`define CAPTURE_DEFS_SVH

`define CAP_CHANNELS        4
`define CAP_FIFO_DEPTH      4
`define CAP_DATA_W          16
`define CAP_ADDR_W          8

// register byte offsets
`define CAP_CH_STRIDE       8'h08
`define CAP_CTRL_OFS        8'h00
`define CAP_BUF_OFS         8'h04
`define CAP_CH_SPAN         8'h20
`define CAP_IRQ_STATUS_OFS  8'h20
`define CAP_IRQ_MASK_OFS    8'h24

// capture_channel_control field positions
`define CAP_MODE_LSB        0
`define CAP_MODE_MSB        2
`define CAP_NOT_EMPTY_BIT   3
`define CAP_OVERFLOW_BIT    4
`define CAP_ICOUNT_LSB      5
`define CAP_ICOUNT_MSB      6
`define CAP_TBSEL_BIT       7

// reset values
`define CAP_MODE_RESET      3'h0
`define CAP_ICOUNT_RESET    2'h0
`define CAP_TBSEL_RESET     1'h0
`define CAP_MASK_RESET      4'h0

// prescaler terminal counts for every 4th and every 16th rising edge
`define CAP_PRESCALE_4_LAST  4'h3
`define CAP_PRESCALE_16_LAST 4'hF

// axi responses
`define CAP_RESP_OKAY       2'h0
`define CAP_RESP_DECERR     2'h3

`endif

// File: capture_pkg.sv
// types shared by the capture unit files
package capture_pkg;

  typedef logic [15:0] capture_word_type;

  // capture_mode_field encodings
  typedef enum logic [2:0] {
    mode_off        = 3'h0,
    mode_every_edge = 3'h1,
    mode_falling    = 3'h2,
    mode_rising     = 3'h3,
    mode_rise4      = 3'h4,
    mode_rise16     = 3'h5,
    mode_spare      = 3'h6,
    mode_irq_only   = 3'h7
  } capture_mode_type;

endpackage

// File: capture_edge_sync.sv
// two-flop pin synchroniser with rise and fall pulses
`timescale 1ns/100ps
module capture_edge_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  logic meta;
  logic stable;
  logic last;

  // meta feeds only stable; edges compare stable with last
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      last   <= 1'b0;
    end else begin
      meta   <= pin;
      stable <= meta;
      last   <= stable;
    end
  end

  assign rise = stable & ~last;
  assign fall = ~stable & last;
endmodule // capture_edge_sync

// File: capture_fifo.sv
// shift-forward capture buffer, oldest word always in slot zero
`timescale 1ns/100ps
module capture_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head,
  output logic                  empty,
  output logic                  full
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] slot [DEPTH];
  logic [CW-1:0]    count;
  logic             do_push;
  logic             do_pop;
  logic [CW-1:0]    wr_pos;

  assign empty   = (count == '0);
  assign full    = (count == CW'(DEPTH));
  assign do_pop  = pop & ~empty;
  assign do_push = push & ~full;
  assign wr_pos  = do_pop ? count - 1'b1 : count;
  assign head    = slot[0];

  // occupancy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (do_push & ~do_pop) begin
      count <= count + 1'b1;
    end else if (do_pop & ~do_push) begin
      count <= count - 1'b1;
    end
  end

  // each slot but the last takes its neighbour on a pop, or the new word at wr_pos
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        slot[i] <= '0;
      end else if (do_push && wr_pos == CW'(i)) begin
        slot[i] <= push_data;
      end else if (do_pop) begin
        slot[i] <= (i + 1 < DEPTH) ? slot[(i + 1) % DEPTH] : slot[i];
      end
    end
  end
endmodule // capture_fifo

// File: input_capture_channels.sv
// four-channel input capture unit with axi4-lite registers
//
// Contract
// - four independent channels, each fully self-contained
// - mode field picks edge or prescaled capture
// - mode off clears the prescaler counter
// - reset clears every prescaler counter
// - each channel buffers four 16-bit captures
// - not-empty flag stays set until drained
// - buffer read returns oldest, shifts rest forward
// - fifth capture into full buffer sets overflow
// - the overflowing capture value is discarded
// - after overflow ignore captures until drained
// - bit 7 picks time base, high timer default
// - every-edge mode interrupts each edge, never overflows
// - bits 6:5 set captures per interrupt
`timescale 1ns/100ps
`include "capture_defs.svh"
module input_capture_channels #(
  parameter int CHANNELS   = `CAP_CHANNELS,
  parameter int FIFO_DEPTH = `CAP_FIFO_DEPTH,
  parameter int ADDR_W     = `CAP_ADDR_W
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // capture pins, asynchronous to aclk
  input  wire logic                          capture_input_a,
  input  wire logic                          capture_input_b,
  input  wire logic                          capture_input_c,
  input  wire logic                          capture_input_d,
  // time bases from the general timers, same clock
  input  wire capture_pkg::capture_word_type general_timer_low,
  input  wire capture_pkg::capture_word_type general_timer_high,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [ADDR_W-1:0]             s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // level interrupt
  output logic                               capture_irq
);
  import capture_pkg::*;

  localparam int CHW = $clog2(CHANNELS);

  // register bus state
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_go;
  logic              ar_go;

  // per-channel state
  logic [CHANNELS-1:0] pins;
  capture_mode_type    mode      [CHANNELS];
  logic [1:0]          icount    [CHANNELS];
  logic [CHANNELS-1:0] tbsel;
  logic [CHANNELS-1:0] not_empty;
  logic [CHANNELS-1:0] overflow;
  logic [CHANNELS-1:0] pop;
  logic [CHANNELS-1:0] event_hit;
  logic [15:0]         head      [CHANNELS];

  // interrupt registers
  logic [CHANNELS-1:0] capture_interrupt_flag;
  logic [CHANNELS-1:0] irq_mask;

  assign pins = CHANNELS'({capture_input_d, capture_input_c,
                           capture_input_b, capture_input_a});

  // address decode helpers
  function automatic logic in_channels(input logic [ADDR_W-1:0] a);
    in_channels = (a < ADDR_W'(`CAP_CH_SPAN)) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [CHW-1:0] ch_of(input logic [ADDR_W-1:0] a);
    ch_of = a[CHW+2:3];
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = in_channels(a) ||
             (a == ADDR_W'(`CAP_IRQ_STATUS_OFS)) ||
             (a == ADDR_W'(`CAP_IRQ_MASK_OFS));
  endfunction

  // write channels are taken independently and held until both are in
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign wr_go         = aw_held & w_held & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CAP_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_addr) ? `CAP_RESP_OKAY : `CAP_RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read: one outstanding, data registered on the address handshake
  assign s_axi_arready = ~s_axi_rvalid;
  assign ar_go         = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `CAP_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
    end else if (ar_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? `CAP_RESP_OKAY
                                           : `CAP_RESP_DECERR;
      s_axi_rdata  <= read_word(s_axi_araddr);
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // read mux; an empty buffer reads as zero rather than stale data
  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
    logic [CHW-1:0] c;
    read_word = 32'h00000000;
    c = ch_of(a);
    if (in_channels(a) && a[2] == 1'b0) begin
      read_word[`CAP_MODE_MSB:`CAP_MODE_LSB]     = mode[c];
      read_word[`CAP_NOT_EMPTY_BIT]              = not_empty[c];
      read_word[`CAP_OVERFLOW_BIT]               = overflow[c];
      read_word[`CAP_ICOUNT_MSB:`CAP_ICOUNT_LSB] = icount[c];
      read_word[`CAP_TBSEL_BIT]                  = tbsel[c];
    end else if (in_channels(a)) begin
      read_word[15:0] = not_empty[c] ? head[c] : 16'h0000;
    end else if (a == ADDR_W'(`CAP_IRQ_STATUS_OFS)) begin
      read_word[CHANNELS-1:0] = capture_interrupt_flag;
    end else if (a == ADDR_W'(`CAP_IRQ_MASK_OFS)) begin
      read_word[CHANNELS-1:0] = irq_mask;
    end
  endfunction

  // one copy of the capture machinery per channel
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
    logic        rise;
    logic        fall;
    logic        edge_ok;
    logic        store_mode;
    logic [3:0]  pre_cnt;
    logic [1:0]  int_cnt;
    logic        fifo_full;
    logic        fifo_empty;
    logic        push;
    logic [15:0] stamp;
    logic        ctrl_wr;

    // pin into aclk domain before any edge logic
    capture_edge_sync u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (pins[ch]),
      .rise    (rise),
      .fall    (fall)
    );

    assign ctrl_wr = wr_go && in_channels(aw_addr) && aw_addr[2] == 1'b0 &&
                     ch_of(aw_addr) == CHW'(ch) && w_strb[0];

    // control fields
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mode[ch]   <= capture_mode_type'(`CAP_MODE_RESET);
        icount[ch] <= `CAP_ICOUNT_RESET;
        tbsel[ch]  <= `CAP_TBSEL_RESET;
      end else if (ctrl_wr) begin
        mode[ch]   <= capture_mode_type'(w_data[`CAP_MODE_MSB:`CAP_MODE_LSB]);
        icount[ch] <= w_data[`CAP_ICOUNT_MSB:`CAP_ICOUNT_LSB];
        tbsel[ch]  <= w_data[`CAP_TBSEL_BIT];
      end
    end

    // prescaler counts rising edges in the divided modes only
    // the spare code is treated as off so it cannot keep a stale count
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pre_cnt <= 4'h0;
      end else if (mode[ch] == mode_off || mode[ch] == mode_spare) begin
        pre_cnt <= 4'h0;
      end else if (rise && mode[ch] == mode_rise4) begin
        pre_cnt <= (pre_cnt >= `CAP_PRESCALE_4_LAST) ? 4'h0 : pre_cnt + 4'h1;
      end else if (rise && mode[ch] == mode_rise16) begin
        pre_cnt <= (pre_cnt == `CAP_PRESCALE_16_LAST) ? 4'h0
                                                      : pre_cnt + 4'h1;
      end
    end

    // qualified capture edge per mode
    always_comb begin
      case (mode[ch])
        mode_every_edge: edge_ok = rise | fall;
        mode_falling:    edge_ok = fall;
        mode_rising:     edge_ok = rise;
        mode_rise4:      edge_ok = rise && pre_cnt >= `CAP_PRESCALE_4_LAST;
        mode_rise16:     edge_ok = rise && pre_cnt == `CAP_PRESCALE_16_LAST;
        mode_irq_only:   edge_ok = rise;
        default:         edge_ok = 1'b0;
      endcase
    end

    // irq-only mode flags edges but stores nothing
    assign store_mode = (mode[ch] != mode_irq_only);

    // a locked-out channel neither stores nor flags edges; only the prescaler still counts them
    assign event_hit[ch] = edge_ok & ~overflow[ch];
    assign push = event_hit[ch] & store_mode & ~fifo_full;

    // stamp from the selected time base, low timer when the bit is set
    assign stamp = tbsel[ch] ? general_timer_low
                             : general_timer_high;

    assign pop[ch] = ar_go && in_channels(s_axi_araddr) &&
                     s_axi_araddr[2] == 1'b1 &&
                     ch_of(s_axi_araddr) == CHW'(ch);

    capture_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH)
    ) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .push      (push),
      .push_data (stamp),
      .pop       (pop[ch]),
      .head      (head[ch]),
      .empty     (fifo_empty),
      .full      (fifo_full)
    );

    assign not_empty[ch] = ~fifo_empty;

    // overflow locks the channel until the buffer has been drained
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        overflow[ch] <= 1'b0;
      end else if (event_hit[ch] && store_mode && fifo_full &&
                   mode[ch] != mode_every_edge) begin
        overflow[ch] <= 1'b1;
      end else if (fifo_empty) begin
        overflow[ch] <= 1'b0;
      end
    end

    // captures-per-interrupt divider, bypassed in every-edge mode
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        int_cnt <= 2'h0;
      end else if (mode[ch] == mode_off || mode[ch] == mode_spare) begin
        int_cnt <= 2'h0;
      end else if (event_hit[ch]) begin
        if (mode[ch] == mode_every_edge || int_cnt == icount[ch]) begin
          int_cnt <= 2'h0;
        end else begin
          int_cnt <= int_cnt + 2'h1;
        end
      end
    end

    // sticky flag, write one clears, a same-cycle event wins
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        capture_interrupt_flag[ch] <= 1'b0;
      end else if (event_hit[ch] &&
                   (mode[ch] == mode_every_edge || mode[ch] == mode_irq_only ||
                    int_cnt == icount[ch])) begin
        capture_interrupt_flag[ch] <= 1'b1;
      end else if (wr_go && aw_addr == ADDR_W'(`CAP_IRQ_STATUS_OFS) &&
                   w_strb[0] && w_data[ch]) begin
        capture_interrupt_flag[ch] <= 1'b0;
      end
    end
  end

  // mask register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= CHANNELS'(`CAP_MASK_RESET);
    end else if (wr_go && aw_addr == ADDR_W'(`CAP_IRQ_MASK_OFS) &&
                 w_strb[0]) begin
      irq_mask <= w_data[CHANNELS-1:0];
    end
  end

  // level interrupt while any unmasked flag stands
  assign capture_irq = |(capture_interrupt_flag & irq_mask);

endmodule // input_capture_channels

// File: input_capture_channels_asserts.sv
// port checker for the capture unit, bound to its top module
`timescale 1ns/100ps
`include "capture_defs.svh"
module capture_port_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              capture_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic buf_rd;

  // remembers whether the pending read targets a buffer word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_rd <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      buf_rd <= s_axi_araddr[2] && (s_axi_araddr < `CAP_CH_SPAN);
    end
  end

  // reset must silence every answer, so no disable here
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !capture_irq)
    else $error("bus or interrupt active after reset");
  AST_AR_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  AST_R_SINGLE: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  AST_W_ANSWER: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  AST_B_SINGLE: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  AST_AR_BLOCK: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_W_BLOCK: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  AST_DECERR_ZERO: assert property (
    s_axi_rvalid && s_axi_rresp == `CAP_RESP_DECERR
    |-> s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  AST_BUF_WIDTH: assert property (
    s_axi_rvalid && buf_rd |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("buffer word wider than 16 bits");
  AST_CTRL_WIDTH: assert property (
    s_axi_rvalid && !buf_rd |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("control word has stray upper bits");

  COV_IRQ: cover property ($rose(capture_irq));
  COV_BUF: cover property (s_axi_rvalid && buf_rd);
  COV_DEC: cover property (s_axi_rvalid && s_axi_rresp[1]);
endmodule // capture_port_checker

bind input_capture_channels capture_port_checker #(.ADDR_W(ADDR_W))
  capture_port_checker_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .capture_irq(capture_irq));

// File: capture_pulse_model.sv
// sensor model driving the four capture pins
`timescale 1ns/100ps
module capture_pulse_model (
  input  wire logic aclk,
  output logic [3:0] pins
);
  initial pins = 4'h0;

  // each level held 6 cycles so the synchroniser surely sees it
  task automatic set_level(input int ch, input logic lvl);
    @(posedge aclk);
    pins[ch] <= lvl;
    repeat (6) @(posedge aclk);
  endtask
endmodule // capture_pulse_model

// File: test_input_capture_channels.sv
// register-level testbench of the capture unit
`timescale 1ns/100ps
`include "capture_defs.svh"
module test_input_capture_channels;
  import capture_pkg::*;
  `define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("unexpected at %0t: got %h want %h", \
    $time, g, e); end end

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] pins;
  capture_word_type tmr_low = 16'h0000;
  capture_word_type tmr_high = 16'h0000;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  int bad_count = 0;
  int total_checks = 0;

  always #2 aclk = ~aclk;

  input_capture_channels input_capture_channels_i (
    .aclk(aclk), .aresetn(aresetn), .capture_input_a(pins[0]),
    .capture_input_b(pins[1]), .capture_input_c(pins[2]),
    .capture_input_d(pins[3]), .general_timer_low(tmr_low),
    .general_timer_high(tmr_high), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .capture_irq(irq));

  capture_pulse_model capture_pulse_model_i (.aclk(aclk), .pins(pins));

  // address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] v);
    bit pa, pw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    do begin
      @(posedge aclk);
      pa = pa && !awready;
      pw = pw && !wready;
      awvalid <= pa;
      wvalid <= pw;
    end while (pa || pw);
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task setm(input int ch, input logic [2:0] m, input logic [1:0] ic = 0,
            input logic tb = 0);
    wr(8'(8 * ch), {24'h0, tb, ic, 2'b00, m});
  endtask

  // {overflow, not empty} of one channel
  task flags(input int ch, input logic [1:0] e);
    rd(8'(8 * ch));
    `CHK(d[4:3], e)
  endtask

  // never called on an empty buffer, which would read as zero
  task pop(input int ch, input logic [15:0] e);
    rd(8'(8 * ch + 4));
    `CHK(d[15:0], e)
  endtask

  // rise stamped s, fall stamped s+1; low timer carries the inverse
  task pulse(input int ch, input logic [15:0] s);
    tmr_high <= s;
    tmr_low <= ~s;
    capture_pulse_model_i.set_level(ch, 1'b1);
    tmr_high <= s + 16'h0001;
    tmr_low <= ~(s + 16'h0001);
    capture_pulse_model_i.set_level(ch, 1'b0);
  endtask

  function automatic logic [15:0] stamp(input logic tb, logic [15:0] v);
    return tb ? ~v : v;
  endfunction

  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // cuts a hang short; the tests need under 3000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    report_and_stop;
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int ch = 0; ch < 4; ch++) begin
      rd(8'(8 * ch));
      `CHK(d, 32'h0)
    end
    rd(8'h30);
    `CHK(r, `CAP_RESP_DECERR)
    wr(8'h30, 32'h0000_00FF);
    `CHK(r, `CAP_RESP_DECERR)
    $display("reset values done");
    // every edge mode on every channel, both time bases
    for (int ch = 0; ch < 4; ch++) begin
      setm(ch, mode_falling, 2'h0, ch[0]);
      pulse(ch, 16'(ch * 256 + 16));
      flags(ch, 2'b01);
      pop(ch, stamp(ch[0], 16'(ch * 256 + 17)));
      flags(ch, 2'b00);
      setm(ch, mode_rising, 2'h0, ch[0]);
      pulse(ch, 16'h0800);
      pop(ch, stamp(ch[0], 16'h0800));
      setm(ch, mode_every_edge, 2'h0, ch[0]);
      pulse(ch, 16'h0900);
      pop(ch, stamp(ch[0], 16'h0900));
      pop(ch, stamp(ch[0], 16'h0901));
    end
    $display("edge modes done");
    setm(1, mode_rising);
    for (int i = 1; i <= 6; i++) pulse(1, 16'(i));
    flags(1, 2'b11);
    for (int i = 1; i <= 3; i++) pop(1, 16'(i));
    pulse(1, 16'h0007);
    pop(1, 16'h0004);
    flags(1, 2'b00);
    pulse(1, 16'h0008);
    pop(1, 16'h0008);
    setm(2, mode_every_edge);
    for (int i = 0; i < 3; i++) pulse(2, 16'(16 * i));
    flags(2, 2'b01);
    for (int i = 0; i < 4; i++) pop(2, 16'(16 * (i / 2) + i % 2));
    $display("buffer and overflow done");
    for (int k = 0; k < 2; k++) begin
      setm(3, mode_rise4);
      pulse(3, 16'h0001);
      pulse(3, 16'h0002);
      if (k == 0) begin
        setm(3, mode_off);
      end else begin
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
      end
      setm(3, mode_rise4);
      for (int i = 0; i < 3; i++) pulse(3, 16'(i + 16));
      flags(3, 2'b00);
      pulse(3, 16'h0040);
      pop(3, 16'h0040);
    end
    setm(0, mode_rise16);
    for (int i = 1; i < 16; i++) pulse(0, 16'(i));
    flags(0, 2'b00);
    pulse(0, 16'h00AB);
    pop(0, 16'h00AB);
    $display("prescaler done");
    // interrupt every second event, then masked and cleared
    setm(1, mode_off);
    setm(1, mode_rising, 2'h1);
    wr(`CAP_IRQ_STATUS_OFS, 32'hF);
    wr(`CAP_IRQ_MASK_OFS, 32'h2);
    pulse(1, 16'h0001);
    rd(`CAP_IRQ_STATUS_OFS);
    `CHK(d[3:0], 4'h0)
    `CHK(irq, 1'b0)
    pulse(1, 16'h0002);
    rd(`CAP_IRQ_STATUS_OFS);
    `CHK(d[3:0], 4'h2)
    `CHK(irq, 1'b1)
    wr(`CAP_IRQ_MASK_OFS, 32'h0);
    `CHK(irq, 1'b0)
    wr(`CAP_IRQ_MASK_OFS, 32'h2);
    wr(`CAP_IRQ_STATUS_OFS, 32'h2);
    `CHK(irq, 1'b0)
    setm(2, mode_every_edge, 2'h3);
    capture_pulse_model_i.set_level(2, 1'b1);
    rd(`CAP_IRQ_STATUS_OFS);
    `CHK(d[2], 1'b1)
    // interrupt-only mode flags the rise but stores nothing
    setm(3, mode_irq_only);
    pulse(3, 16'h0050);
    flags(3, 2'b00);
    rd(`CAP_IRQ_STATUS_OFS);
    `CHK(d[3], 1'b1)
    $display("interrupt done");
    report_and_stop;
  end
endmodule // test_input_capture_channels
